// ### scp_serial_port.sv
// Operation
// - cycle opens with a 16-bit instruction, MSB first by default
// - instruction top bit one means read, zero means write
// - instruction bits 9 to 0 give the starting register address
// - instruction bits 14 and 13 give the transfer length field
// - serial input is captured on serial clock rising edges
// - chip select low opens a cycle, chip select high ends it
// - read data is driven out after serial clock falling edges
// - setup register at zero holds mirrored bit pairs, resets to 0x18
// - readback select bit 0 picks active registers or buffer, resets zero
// - length 00/01/10 moves one to three bytes, 11 streams
// - readback select writes land in buffer; update bit at 0x232 activates them, self-clearing; setup writes act at once
// - MSB first decrements address, LSB first increments, streaming stops at 0x232
// - readback on data pin unless output-pin enable moves it to the output pin
module scp_serial_port (
    // clock and reset
    input  logic core_clk,
    input  logic srst,
    // serial pins from the host
    input  logic csN,
    input  logic sclk,
    // bidirectional data pin
    input  logic sdioIn,
    output logic sdioOut,
    output logic sdioOe,
    // dedicated readback pin
    output logic serialReadbackOut,
    output logic serialReadbackOutOe,
    // status
    output logic updatePulse,
    output logic readbackActive
);
    // synchronised pins: [0] csN, [1] sclk, [2] sdio
    logic [2:0]             pinMeta_q;
    logic [2:0]             pinSync_q;
    logic                   sclkPrev_q;
    logic                   csPrev_q;
    logic                   sclkRise;
    logic                   sclkFall;
    logic                   csRise;
    logic                   csFall;
    logic                   csLow;
    logic                   sdioS;

    scp_pkg::scp_state_t    state_q;
    logic [3:0]             bitCnt_q;
    logic [15:0]            instr_q;
    logic [15:0]            instrNext;
    logic [7:0]             rxNext;
    logic [7:0]             tx_q;
    logic                   isRead_q;
    logic [1:0]             len_q;
    logic [1:0]             byteIdx_q;
    logic [9:0]             addr_q;
    logic [9:0]             addrNext;
    logic                   byteDone;
    logic                   lastByte;
    logic                   dataOut_q;

    logic [7:0]             setup_q;
    logic [7:0]             rbBuf_q;
    logic [7:0]             rbAct_q;
    logic                   update_q;
    logic                   lsbFirst;
    logic                   outPinEn;

    logic                   fifoWrValid;
    logic                   fifoWrReady;
    logic [17:0]            fifoWrData;
    logic                   fifoRdValid;
    logic                   fifoRdReady;
    logic [17:0]            fifoRdData;
    logic [9:0]             popAddr;
    logic [7:0]             popByte;
    logic                   pop;

    // two flip-flops per pin; only the second stage is looked at
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pinMeta_q <= 3'h7;
            pinSync_q <= 3'h7;
        end else begin
            pinMeta_q <= {sdioIn, sclk, csN};
            pinSync_q <= pinMeta_q;
        end
    end

    // edge history of the synchronised clock and select
    always_ff @(posedge core_clk) begin
        if (srst) begin
            sclkPrev_q <= 1'b1;
            csPrev_q   <= 1'b1;
        end else begin
            sclkPrev_q <= pinSync_q[1];
            csPrev_q   <= pinSync_q[0];
        end
    end

    assign csLow    = !pinSync_q[0];
    assign csRise   = pinSync_q[0] && !csPrev_q;
    assign csFall   = !pinSync_q[0] && csPrev_q;
    assign sclkRise = csLow && pinSync_q[1] && !sclkPrev_q;
    assign sclkFall = csLow && !pinSync_q[1] && sclkPrev_q;
    assign sdioS    = pinSync_q[2];

    // mirrored pairs: either copy turns the function on
    assign lsbFirst = setup_q[scp_pkg::LSB_HI] | setup_q[scp_pkg::LSB_LO];
    assign outPinEn = setup_q[scp_pkg::OUT_EN_HI] | setup_q[scp_pkg::OUT_EN_LO];

    // bit order decides which end the serial bit enters
    assign instrNext = lsbFirst ? {sdioS, instr_q[15:1]} : {instr_q[14:0], sdioS};
    assign rxNext    = lsbFirst ? {sdioS, instr_q[7:1]} : {instr_q[6:0], sdioS};

    assign byteDone = (state_q == scp_pkg::ST_DATA) && sclkRise && (bitCnt_q[2:0] == scp_pkg::BIT_LAST);
    // streaming ends only on the top address or on chip select
    assign lastByte = (len_q == scp_pkg::LEN_STREAM) ? (addr_q == scp_pkg::ADDR_LAST)
                                                     : (byteIdx_q == len_q);

    // next address: decrement wraps from zero to the top, as the stop sequence shows
    always_comb begin
        if (lsbFirst) begin
            addrNext = 10'(addr_q + 1'b1);
        end else if (addr_q == scp_pkg::ADDR_FIRST) begin
            addrNext = scp_pkg::ADDR_LAST;
        end else begin
            addrNext = 10'(addr_q - 1'b1);
        end
    end

    // register readback, source chosen by the active select bit
    function automatic logic [7:0] regRead(input logic [9:0] a, input logic [7:0] setup,
                                           input logic [7:0] rbBuf, input logic [7:0] rbAct);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            scp_pkg::OFS_SETUP:   v = setup;
            scp_pkg::OFS_PART_IDENTIFIER: v = scp_pkg::PART_IDENTIFIER_VAL;
            scp_pkg::OFS_RB_SEL:  v = rbAct[scp_pkg::RB_SEL_BIT] ? rbAct : rbBuf;
            default:              v = 8'h00;
        endcase
        return v;
    endfunction : regRead

    // cycle sequencer
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state_q   <= scp_pkg::ST_IDLE;
            bitCnt_q  <= 4'h0;
            instr_q   <= 16'h0000;
            isRead_q  <= 1'b0;
            len_q     <= 2'h0;
            byteIdx_q <= 2'h0;
            addr_q    <= 10'h000;
        end else if (!csLow) begin
            state_q <= scp_pkg::ST_IDLE;
        end else begin
            case (state_q)
                scp_pkg::ST_IDLE: begin
                    if (csFall) begin
                        state_q  <= scp_pkg::ST_INSTR;
                        bitCnt_q <= 4'h0;
                    end
                end
                scp_pkg::ST_INSTR: begin
                    if (sclkRise) begin
                        instr_q  <= instrNext;
                        bitCnt_q <= 4'(bitCnt_q + 1'b1);
                        if (bitCnt_q == scp_pkg::INSTR_LAST) begin
                            state_q   <= scp_pkg::ST_DATA;
                            isRead_q  <= (instrNext[scp_pkg::DIR_BIT] == scp_pkg::DIR_READ);
                            len_q     <= instrNext[scp_pkg::LEN_HI:scp_pkg::LEN_LO];
                            addr_q    <= instrNext[scp_pkg::ADDR_HI:0];
                            byteIdx_q <= 2'h0;
                        end
                    end
                end
                scp_pkg::ST_DATA: begin
                    if (sclkRise) begin
                        instr_q  <= {instr_q[15:8], rxNext};
                        bitCnt_q <= 4'(bitCnt_q + 1'b1);
                        if (byteDone) begin
                            byteIdx_q <= 2'(byteIdx_q + 1'b1);
                            addr_q    <= addrNext;
                            if (lastByte) begin
                                state_q <= scp_pkg::ST_DONE;
                            end
                        end
                    end
                end
                scp_pkg::ST_DONE: begin
                    state_q <= scp_pkg::ST_DONE;
                end
                default: begin
                    state_q <= scp_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // readback shifter: loaded on the rising edge before each byte, shifted on falls
    always_ff @(posedge core_clk) begin
        if (srst) begin
            tx_q      <= 8'h00;
            dataOut_q <= 1'b0;
        end else if (state_q == scp_pkg::ST_INSTR && sclkRise && bitCnt_q == scp_pkg::INSTR_LAST) begin
            tx_q <= regRead(instrNext[scp_pkg::ADDR_HI:0], setup_q, rbBuf_q, rbAct_q);
        end else if (byteDone && isRead_q) begin
            tx_q <= regRead(addrNext, setup_q, rbBuf_q, rbAct_q);
        end else if (sclkFall && state_q == scp_pkg::ST_DATA && isRead_q) begin
            dataOut_q <= lsbFirst ? tx_q[0] : tx_q[7];
            tx_q      <= lsbFirst ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
        end
    end

    // pin steering; the data pin stays an input unless a read is under way
    assign sdioOut             = dataOut_q;
    assign serialReadbackOut   = dataOut_q;
    assign sdioOe              = (state_q == scp_pkg::ST_DATA) && isRead_q && !outPinEn;
    assign serialReadbackOutOe = (state_q == scp_pkg::ST_DATA) && isRead_q && outPinEn;

    // written bytes queue up; a byte that meets a full queue is lost
    assign fifoWrValid = byteDone && !isRead_q;
    assign fifoWrData  = {addr_q, rxNext};
    // drain holds off during reads so a readback never sees a half-applied burst
    assign fifoRdReady = !((state_q == scp_pkg::ST_DATA) && isRead_q);
    assign pop         = fifoRdValid && fifoRdReady;
    assign popAddr     = fifoRdData[17:8];
    assign popByte     = fifoRdData[7:0];

    scp_fifo #(
        .WIDTH (scp_pkg::FIFO_W),
        .DEPTH (scp_pkg::FIFO_DEPTH)
    ) u_fifo (
        .core_clk (core_clk),
        .srst     (srst),
        .wrValid  (fifoWrValid),
        .wrReady  (fifoWrReady),
        .wrData   (fifoWrData),
        .rdValid  (fifoRdValid),
        .rdReady  (fifoRdReady),
        .rdData   (fifoRdData)
    );

    // setup acts at once; soft reset restores defaults and clears itself
    always_ff @(posedge core_clk) begin
        if (srst) begin
            setup_q <= scp_pkg::SETUP_RST;
            rbBuf_q <= scp_pkg::RB_SEL_RST;
            rbAct_q <= scp_pkg::RB_SEL_RST;
        end else if (pop) begin
            case (popAddr)
                scp_pkg::OFS_SETUP: begin
                    if (popByte[scp_pkg::SRST_HI] | popByte[scp_pkg::SRST_LO]) begin
                        setup_q <= scp_pkg::SETUP_RST;
                        rbBuf_q <= scp_pkg::RB_SEL_RST;
                        rbAct_q <= scp_pkg::RB_SEL_RST;
                    end else begin
                        setup_q <= popByte;
                    end
                end
                scp_pkg::OFS_RB_SEL: begin
                    rbBuf_q <= {7'h00, popByte[scp_pkg::RB_SEL_BIT]};
                end
                scp_pkg::OFS_UPDATE: begin
                    if (popByte[scp_pkg::UPDATE_BIT]) begin
                        rbAct_q <= rbBuf_q;
                    end
                end
                default: begin
                    rbAct_q <= rbAct_q;
                end
            endcase
        end
    end

    // update is a pulse, so the bit reads back as zero
    always_ff @(posedge core_clk) begin
        if (srst) begin
            update_q <= 1'b0;
        end else begin
            update_q <= pop && (popAddr == scp_pkg::OFS_UPDATE) && popByte[scp_pkg::UPDATE_BIT];
        end
    end

    assign updatePulse    = update_q;
    assign readbackActive = rbAct_q[scp_pkg::RB_SEL_BIT];

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);

    setup_rst_val_a: assert property (disable iff (1'b0) srst |=> setup_q == scp_pkg::SETUP_RST)
        else $error("setup register not at reset value");
    rbsel_rst_val_a: assert property (disable iff (1'b0) srst |=> rbBuf_q == 8'h00 && rbAct_q == 8'h00)
        else $error("readback select not cleared by reset");
    cs_end_idle_a: assert property (csRise |=> state_q == scp_pkg::ST_IDLE)
        else $error("chip select rise did not end the cycle");
    instr_addr_a: assert property ((state_q == scp_pkg::ST_INSTR && sclkRise
        && bitCnt_q == scp_pkg::INSTR_LAST) |=> addr_q == $past(instrNext[9:0]) && state_q == scp_pkg::ST_DATA)
        else $error("start address not taken from instruction");
    instr_dir_a: assert property ((state_q == scp_pkg::ST_INSTR && sclkRise
        && bitCnt_q == scp_pkg::INSTR_LAST) |=> isRead_q == $past(instrNext[15]))
        else $error("direction bit misdecoded");
    instr_len_a: assert property ((state_q == scp_pkg::ST_INSTR && sclkRise
        && bitCnt_q == scp_pkg::INSTR_LAST) |=> len_q == $past(instrNext[14:13]) && byteIdx_q == 2'h0)
        else $error("length field misdecoded");
    pin_exclusive_a: assert property (!(sdioOe && serialReadbackOutOe) && !(sdioOe && outPinEn))
        else $error("readback driven on the wrong pin");
    oe_read_only_a: assert property ((sdioOe || serialReadbackOutOe) |-> isRead_q && $past(csLow))
        else $error("readback driven outside a read");
    update_copy_a: assert property ((pop && popAddr == scp_pkg::OFS_UPDATE && popByte[0])
        |=> rbAct_q == $past(rbBuf_q) && updatePulse)
        else $error("update did not activate buffer");
    stream_stop_a: assert property ((byteDone && len_q == scp_pkg::LEN_STREAM
        && addr_q == scp_pkg::ADDR_LAST) |=> state_q != scp_pkg::ST_DATA)
        else $error("stream ran past the top address");
    addr_step_a: assert property ((byteDone && !lastByte && !lsbFirst && addr_q != 10'h000)
        |=> addr_q == 10'($past(addr_q) - 1'b1))
        else $error("address did not decrement");
    count_end_a: assert property ((byteDone && len_q != scp_pkg::LEN_STREAM && byteIdx_q == len_q)
        |=> state_q == scp_pkg::ST_DONE)
        else $error("fixed length transfer did not end");
    write_push_a: assert property ((byteDone && !isRead_q) |-> fifoWrValid && fifoWrData[7:0] == rxNext)
        else $error("written byte not queued");
    done_ignores_a: assert property ((state_q == scp_pkg::ST_DONE && csLow) |=> !fifoWrValid)
        else $error("bits accepted after transfer end");

    write_seen_c:  cover property (fifoWrValid ##[1:200] pop);
    read_seen_c:   cover property (sdioOe ##1 sclkFall);
    stream_seen_c: cover property (byteDone && len_q == scp_pkg::LEN_STREAM ##[1:400] byteDone);
    update_seen_c: cover property (updatePulse);

endmodule : scp_serial_port

// ### scp_pkg.sv
package scp_pkg;

    // instruction word layout
    localparam int          INSTR_W       = 16;
    localparam int          ADDR_W        = 10;
    localparam int          BYTE_W        = 8;
    localparam int          DIR_BIT       = 15;
    localparam int          LEN_HI        = 14;
    localparam int          LEN_LO        = 13;
    localparam int          ADDR_HI       = 9;
    localparam logic        DIR_READ      = 1'b1;
    localparam logic [1:0]  LEN_STREAM    = 2'h3;
    localparam logic [3:0]  INSTR_LAST    = 4'hF;
    localparam logic [2:0]  BIT_LAST      = 3'h7;

    // register offsets
    localparam logic [9:0]  OFS_SETUP     = 10'h000;
    localparam logic [9:0]  OFS_PART_IDENTIFIER   = 10'h003;
    localparam logic [9:0]  OFS_RB_SEL    = 10'h004;
    localparam logic [9:0]  OFS_UPDATE    = 10'h232;
    localparam logic [9:0]  ADDR_FIRST    = 10'h000;
    localparam logic [9:0]  ADDR_LAST     = 10'h232;

    // serial_port_setup fields, each mirrored
    localparam int          OUT_EN_HI     = 7;
    localparam int          OUT_EN_LO     = 0;
    localparam int          LSB_HI        = 6;
    localparam int          LSB_LO        = 1;
    localparam int          SRST_HI       = 5;
    localparam int          SRST_LO       = 2;
    localparam logic [7:0]  SETUP_RST     = 8'h18;
    localparam logic [7:0]  RB_SEL_RST    = 8'h00;
    localparam int          RB_SEL_BIT    = 0;
    localparam int          UPDATE_BIT    = 0;
    localparam logic [7:0]  PART_IDENTIFIER_VAL   = 8'h5A; // arbitrary neutral value

    // write fifo
    localparam int          FIFO_W        = ADDR_W + BYTE_W;
    localparam int          FIFO_DEPTH    = 8;

    // port sequencer states
    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_INSTR = 4'b0010,
        ST_DATA  = 4'b0100,
        ST_DONE  = 4'b1000
    } scp_state_t;

endpackage : scp_pkg

// ### scp_fifo.sv
module scp_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    // clock and reset
    input  logic             core_clk,
    input  logic             srst,
    // fill side
    input  logic             wrValid,
    output logic             wrReady,
    input  logic [WIDTH-1:0] wrData,
    // drain side
    output logic             rdValid,
    input  logic             rdReady,
    output logic [WIDTH-1:0] rdData
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wrPtr_q;
    logic [PW-1:0]    rdPtr_q;
    logic [PW:0]      count_q;
    logic [WIDTH-1:0] outData_q;
    logic             outValid_q;
    logic             push;
    logic             load;

    // output register refills whenever it is empty or being drained
    assign wrReady = (count_q < (PW+1)'(DEPTH));
    assign push    = wrValid && wrReady;
    assign load    = (count_q != '0) && (!outValid_q || rdReady);
    assign rdValid = outValid_q;
    assign rdData  = outData_q;

    // storage, no reset needed on the array itself
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem[wrPtr_q] <= wrData;
        end
    end

    // pointers and occupancy
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wrPtr_q <= PW'(wrPtr_q + 1'b1);
            end
            if (load) begin
                rdPtr_q <= PW'(rdPtr_q + 1'b1);
            end
            count_q <= (PW+1)'(count_q + (PW+1)'(push) - (PW+1)'(load));
        end
    end

    // registered head word
    always_ff @(posedge core_clk) begin
        if (srst) begin
            outValid_q <= 1'b0;
            outData_q  <= '0;
        end else if (load) begin
            outValid_q <= 1'b1;
            outData_q  <= mem[rdPtr_q];
        end else if (rdReady) begin
            outValid_q <= 1'b0;
        end
    end

endmodule : scp_fifo

// ### scp_host_model.sv
module scp_host_model (
    // link pins driven by the host
    output logic     csN,
    output logic     sclk,
    output logic     hostSdio,
    // readback seen by the host
    input  wire logic sdioW,
    input  wire logic rbPin,
    input  wire logic sdioOe,
    input  wire logic rbPinOe
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle: not selected, link clock parked low
    initial begin
        csN = 1'b1;
        sclk = 1'b0;
        hostSdio = 1'b0;
    end

    // one frame: 16 instruction bits then n data bits; n not a multiple of 8 aborts
    task automatic xfer(input logic [15:0] ins, input int n, input logic [23:0] wd, input bit lsb,
                        input bit pin, output logic [23:0] rd, output bit ok);
        int p;
        int k;
        rd = 24'h00_0000;
        ok = 1'b1;
        csN = 1'b0;
        #100;
        for (int i = 0; i < 16 + n; i++) begin
            k = (i - 16) / 8;
            p = (i < 16) ? (lsb ? i : 15 - i) : (lsb ? (i - 16) % 8 : 7 - (i - 16) % 8);
            if (i < 16)
                hostSdio = ins[p];
            else if (!ins[15])
                hostSdio = wd[16 - 8 * k + p];
            else
                hostSdio = ~hostSdio; // released line keeps moving so stale bits never match
            #32;
            // sample readback just before the rise, data held across it
            if (i >= 16 && ins[15]) begin
                rd[16 - 8 * k + p] = pin ? rbPin : sdioW;
                ok &= pin ? (rbPinOe === 1'b1 && sdioOe === 1'b0) : (sdioOe === 1'b1 && rbPinOe === 1'b0);
            end
            sclk = 1'b1;
            #32;
            sclk = 1'b0;
        end
        #32;
        csN = 1'b1;
        #60;
    endtask : xfer

endmodule : scp_host_model

// ### scp_serial_port_tb.sv
module scp_serial_port_tb;
    timeunit 1ns;
    timeprecision 1ps;

    typedef struct {
        logic [15:0] ins;
        int          n;
        logic [23:0] wd;
        logic [23:0] ex;
    } scp_row_t;

    logic core_clk;
    logic srst;
    logic csN;
    logic sclk;
    logic hostSdio;
    logic sdioW;
    logic sdioOut;
    logic sdioOe;
    logic rbPin;
    logic rbOut;
    logic rbPinOe;
    logic updatePulse;
    logic readbackActive;
    int   errorCnt;
    int   numChecks;
    int   updCnt;

    // plain reads of reset values, writes to buffer and reserved slot, multibyte reads
    scp_row_t rows [8] = '{
        '{16'h8000, 8, 24'h00_0000, 24'h18_0000},
        '{16'h8003, 8, 24'h00_0000, 24'h5A_0000},
        '{16'h8004, 8, 24'h00_0000, 24'h00_0000},
        '{16'h0004, 8, 24'h01_0000, 24'h00_0000},
        '{16'h8004, 8, 24'h00_0000, 24'h01_0000},
        '{16'hA004, 16, 24'h00_0000, 24'h01_5A00},
        '{16'h0002, 8, 24'hFF_0000, 24'h00_0000},
        '{16'hC004, 24, 24'h00_0000, 24'h01_5A00}
    };

    // data pin level: device wins while it drives
    assign sdioW = sdioOe ? sdioOut : hostSdio;
    // released readback pin shows the inverse, so a stale bit on an idle pin cannot match
    assign rbPin = rbPinOe ? rbOut : ~rbOut;

    scp_serial_port DUT (.core_clk(core_clk), .srst(srst), .csN(csN), .sclk(sclk), .sdioIn(sdioW),
        .sdioOut(sdioOut), .sdioOe(sdioOe), .serialReadbackOut(rbOut), .serialReadbackOutOe(rbPinOe),
        .updatePulse(updatePulse), .readbackActive(readbackActive));

    scp_host_model host (.csN(csN), .sclk(sclk), .hostSdio(hostSdio), .sdioW(sdioW), .rbPin(rbPin),
        .sdioOe(sdioOe), .rbPinOe(rbPinOe));

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // count update strobes
    always @(posedge core_clk) begin
        if (srst)
            updCnt <= 0;
        else if (updatePulse === 1'b1)
            updCnt <= updCnt + 1;
    end

    task automatic chkData(input logic [23:0] got, input logic [23:0] ex);
        numChecks++;
        if (got !== ex) begin
            errorCnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask : chkData

    task automatic chkFlag(input logic got, input logic ex);
        numChecks++;
        if (got !== ex) begin
            errorCnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, ex);
        end
    endtask : chkFlag

    task automatic run(input logic [15:0] ins, input int n, input logic [23:0] wd, input bit lsb,
                       input bit pin, input logic [23:0] ex);
        logic [23:0] rd;
        bit          ok;
        host.xfer(ins, n, wd, lsb, pin, rd, ok);
        if (ins[15]) begin
            chkData(rd, ex);
            chkFlag(ok, 1'b1);
        end
    endtask : run

    task automatic stop_test;
        $display("checks %0d mismatches %0d", numChecks, errorCnt);
        if (errorCnt == 0 && numChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test

    // hang guard far beyond the whole sequence
    initial begin
        #400000;
        errorCnt++;
        stop_test();
    end

    initial begin
        errorCnt = 0;
        numChecks = 0;
        srst = 1'b1;
        repeat (16) @(negedge core_clk);
        srst = 1'b0;
        repeat (4) @(negedge core_clk);
        chkFlag(sdioOe | rbPinOe | readbackActive | updatePulse, 1'b0);
        $display("test reset done");
        foreach (rows[i]) begin
            run(rows[i].ins, rows[i].n, rows[i].wd, 1'b0, 1'b0, rows[i].ex);
            $display("test row %0d done", i);
        end
        // update moves buffer to active, active copy then wins on readback
        run(16'h0232, 8, 24'h01_0000, 1'b0, 1'b0, 24'h00_0000);
        chkFlag(updCnt == 1, 1'b1);
        chkFlag(readbackActive, 1'b1);
        run(16'h0004, 8, 24'h00_0000, 1'b0, 1'b0, 24'h00_0000);
        run(16'h8004, 8, 24'h00_0000, 1'b0, 1'b0, 24'h01_0000);
        $display("test update done");
        // stream wraps 0x001, 0x000, 0x232
        run(16'hE001, 24, 24'h00_0000, 1'b0, 1'b0, 24'h00_1800);
        $display("test stream done");
        // readback moved to the dedicated pin
        run(16'h0000, 8, 24'h99_0000, 1'b0, 1'b0, 24'h00_0000);
        run(16'h8003, 8, 24'h00_0000, 1'b0, 1'b1, 24'h5A_0000);
        $display("test out pin done");
        // lsb first: address increments 0x003 then 0x004
        run(16'h0000, 8, 24'h5A_0000, 1'b0, 1'b1, 24'h00_0000);
        run(16'hA003, 16, 24'h00_0000, 1'b1, 1'b0, 24'h5A_0100);
        $display("test lsb first done");
        // soft reset restores setup and both select copies
        run(16'h0000, 8, 24'h24_0000, 1'b1, 1'b0, 24'h00_0000);
        run(16'h8000, 8, 24'h00_0000, 1'b0, 1'b0, 24'h18_0000);
        chkFlag(readbackActive, 1'b0);
        $display("test soft reset done");
        // aborted half byte leaves register alone, next frame decodes again
        run(16'h0004, 4, 24'hF0_0000, 1'b0, 1'b0, 24'h00_0000);
        run(16'h8004, 8, 24'h00_0000, 1'b0, 1'b0, 24'h00_0000);
        run(16'h8003, 8, 24'h00_0000, 1'b0, 1'b0, 24'h5A_0000);
        $display("test abort done");
        stop_test();
    end

endmodule : scp_serial_port_tb
